// File: osc_defines.svh
// constants for the oscillator select block
`ifndef OSC_DEFINES_SVH
`define OSC_DEFINES_SVH
`define OSC_ADDR_CTRL 12'h000
`define OSC_ADDR_STAT 12'h004
`define OSC_ADDR_PERIPH 12'h008
`define OSC_IFS_RESET 4'h7
`define OSC_SCS_RESET 2'h0
`define OSC_BOOT_INTERNAL_OSC_MODE 2'h0
`define OSC_CLK_HZ 20000000
`define OSC_HF_START_NS 2000
`define OSC_HF_START_CYC (((`OSC_HF_START_NS * (`OSC_CLK_HZ / 1000000)) + 999) / 1000)
`define OSC_HF_STABLE_CYC 8'd80
`define OSC_LF_START_CYC 8'd4
`define OSC_HF_CNT_W 8
`endif

// File: osc_pkg.sv
// types for the oscillator select block
package osc_pkg;
  typedef enum logic [2:0] {
    osc_src_ext_low = 3'b001,
    osc_src_ext_medium = 3'b010,
    osc_src_ext_high = 3'b011,
    osc_src_hf = 3'b100,
    osc_src_lf = 3'b101
  } osc_src_t;
  typedef struct packed {
    logic hf_ready_flag;
    logic lf_ready_flag;
    logic hf_stable_flag;
  } osc_status_t;
  typedef struct packed {
    logic adc_sel_rc;
    logic wave_sel_hf;
    logic nco_sel_hf;
    logic pwm_sel_t2;
    logic t1_sel_lf;
  } osc_route_t;
endpackage

// File: osc_select.sv
// oscillator and system clock source selection with apb registers
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "osc_defines.svh"
module osc_select
  import osc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration bits
  input wire logic [1:0] boot_clock_select,
  input wire logic clock_out_enable_n,
  input wire logic powerup_timer_en,
  input wire logic watchdog_timer_en,
  input wire logic sleep_mode,
  // peripheral rc clock requests
  input wire logic periph_rc_req,
  // clock pin control
  output logic clock_in_pin_is_io,
  output logic clock_out_pin_oe,
  output logic clock_out_pin_is_io,
  // oscillator enables and state
  output logic hf_osc_en,
  output logic lf_osc_en,
  output logic periph_rc_en,
  output logic startup_osc_active,
  output osc_src_t sys_src,
  output logic [3:0] hf_postscale,
  output osc_route_t route_sel
);
  // software registers
  logic [3:0] int_freq_select; // postscaler / source choice
  logic [1:0] sys_clock_select; // run-time clock source
  osc_route_t route_reg; // peripheral clock routing
  osc_status_t status; // ready/stable flags
  logic [`OSC_HF_CNT_W-1:0] hf_cnt; // hf start and settle count
  logic [`OSC_HF_CNT_W-1:0] lf_cnt; // lf start count
  logic [`OSC_HF_CNT_W-1:0] next_hf_cnt;
  logic [`OSC_HF_CNT_W-1:0] next_lf_cnt;
  osc_src_t next_src;
  logic [31:0] next_rdata;

  // bus decode
  wire logic wr_en = psel && penable && pwrite;
  wire logic rd_en = psel && penable && !pwrite;
  wire logic hit_ctrl = paddr == `OSC_ADDR_CTRL;
  wire logic hit_stat = paddr == `OSC_ADDR_STAT;
  wire logic hit_per = paddr == `OSC_ADDR_PERIPH;
  wire logic hit_any = hit_ctrl || hit_stat || hit_per;

  // selection decode
  wire logic use_int = sys_clock_select[1] || boot_clock_select == `OSC_BOOT_INTERNAL_OSC_MODE;
  wire logic lf_freq = int_freq_select[3:1] == 3'b000;
  // 001x is the 31.25 khz setting, fed from hf by postscale
  wire logic hf_freq = !lf_freq;
  wire logic hf_need = (int_freq_select[3:1] != 3'b000) && use_int;
  wire logic lf_need = (lf_freq && use_int) || powerup_timer_en || watchdog_timer_en;
  wire logic hf_running = hf_cnt >= `OSC_HF_CNT_W'(`OSC_HF_START_CYC);
  wire logic hf_settled = hf_cnt == `OSC_HF_STABLE_CYC;
  wire logic lf_running = lf_cnt == `OSC_LF_START_CYC;

  // next source: boot decode or internal block
  always_comb begin
    if (use_int) begin
      next_src = lf_freq ? osc_src_lf : osc_src_hf;
    end else begin
      unique case (boot_clock_select)
        2'b11: next_src = osc_src_ext_high;
        2'b10: next_src = osc_src_ext_medium;
        default: next_src = osc_src_ext_low;
      endcase
    end
  end

  // oscillator start counters; hold at the top value
  always_comb begin
    next_hf_cnt = hf_cnt;
    next_lf_cnt = lf_cnt;
    if (!hf_need) begin
      next_hf_cnt = '0;
    end else if (!hf_settled) begin
      next_hf_cnt = hf_cnt + `OSC_HF_CNT_W'(1);
    end
    if (!lf_need) begin
      next_lf_cnt = '0;
    end else if (!lf_running) begin
      next_lf_cnt = lf_cnt + `OSC_HF_CNT_W'(1);
    end
  end

  // read mux; unmapped reads as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_ctrl) begin
      next_rdata = {25'h0, int_freq_select, 1'b0, sys_clock_select};
    end else if (hit_stat) begin
      next_rdata = {27'h0, status.hf_ready_flag, 2'b00, status.lf_ready_flag,
        status.hf_stable_flag};
    end else if (hit_per) begin
      next_rdata = {27'h0, route_reg};
    end
  end

  // register writes
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      int_freq_select <= `OSC_IFS_RESET;
      sys_clock_select <= `OSC_SCS_RESET;
      route_reg <= '0;
    end else if (wr_en && hit_ctrl) begin
      int_freq_select <= pwdata[6:3];
      sys_clock_select <= pwdata[1:0];
    end else if (wr_en && hit_per) begin
      route_reg <= pwdata[4:0];
    end
  end

  // apb answer: zero wait state, error on unmapped address
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit_any;
      prdata <= (psel && !penable && !pwrite) ? next_rdata : prdata;
    end
  end

  // oscillator state and status flags
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hf_cnt <= '0;
      lf_cnt <= '0;
      status <= '0;
    end else begin
      hf_cnt <= next_hf_cnt;
      lf_cnt <= next_lf_cnt;
      status.hf_ready_flag <= hf_need && (next_hf_cnt >= `OSC_HF_CNT_W'(`OSC_HF_START_CYC));
      status.hf_stable_flag <= hf_need && next_hf_cnt == `OSC_HF_STABLE_CYC;
      status.lf_ready_flag <= lf_need && next_lf_cnt == `OSC_LF_START_CYC;
    end
  end

  // system source switch: a new hf or lf source is taken only once it runs,
  // so hf is taken at the start count before it settles; external sources are taken at once
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sys_src <= osc_src_hf;
    end else if ((next_src == osc_src_hf && !hf_running) ||
                 (next_src == osc_src_lf && !lf_running)) begin
      sys_src <= sys_src;
    end else begin
      sys_src <= next_src;
    end
  end

  // pins, enables and routing, all registered
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      clock_in_pin_is_io <= 1'b0;
      clock_out_pin_oe <= 1'b0;
      clock_out_pin_is_io <= 1'b1;
      hf_osc_en <= 1'b0;
      lf_osc_en <= 1'b0;
      periph_rc_en <= 1'b0;
      startup_osc_active <= 1'b1;
      hf_postscale <= `OSC_IFS_RESET;
      route_sel <= '0;
    end else begin
      clock_in_pin_is_io <= boot_clock_select == `OSC_BOOT_INTERNAL_OSC_MODE;
      clock_out_pin_oe <= !clock_out_enable_n;
      clock_out_pin_is_io <= clock_out_enable_n;
      hf_osc_en <= hf_need;
      lf_osc_en <= lf_need;
      periph_rc_en <= periph_rc_req;
      startup_osc_active <= !(hf_need && next_hf_cnt == `OSC_HF_STABLE_CYC);
      hf_postscale <= hf_freq ? int_freq_select : 4'h0;
      route_sel <= route_reg;
    end
  end

  // sleep does not gate the rc clock: it follows the request only
  wire logic unused_sleep = sleep_mode;
endmodule

// File: osc_select_assertions.sv
// checker for the oscillator select block
`timescale 1ns/1ps
module osc_select_checker
  import osc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // apb handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // config and pins
  input wire logic [1:0] boot_clock_select,
  input wire logic clock_out_enable_n,
  input wire logic clock_out_pin_oe,
  input wire logic clock_out_pin_is_io,
  input wire logic clock_in_pin_is_io,
  // oscillators
  input wire logic powerup_timer_en,
  input wire logic watchdog_timer_en,
  input wire logic periph_rc_req,
  input wire logic periph_rc_en,
  input wire logic lf_osc_en,
  input wire osc_src_t sys_src
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_clkout_cfg: assert property ($past(resetn) |-> clock_out_pin_oe == !$past(clock_out_enable_n))
    else $error("clock out enable wrong");
  a_clkout_role: assert property (clock_out_pin_oe != clock_out_pin_is_io)
    else $error("clock out role wrong");
  a_clock_input_pin_free: assert property ($past(resetn) |-> clock_in_pin_is_io == ($past(boot_clock_select) == 2'h0))
    else $error("clock in pin role wrong");
  a_rc_follow: assert property ($past(resetn) |-> periph_rc_en == $past(periph_rc_req))
    else $error("rc clock not following request");
  a_lf_timer: assert property ($past(resetn) && ($past(powerup_timer_en) || $past(watchdog_timer_en)) |-> lf_osc_en)
    else $error("lf off with timer on");
  a_ext_decode: assert property (!sys_src[2] |-> sys_src[1:0] == boot_clock_select)
    else $error("external mode decode wrong");
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no zero wait answer");
  a_err_pair: assert property (pslverr |-> pready && penable)
    else $error("error without ready");
endmodule
bind osc_select osc_select_checker osc_select_checker_inst (.mclk, .resetn, .psel, .penable, .pready,
  .pslverr, .boot_clock_select, .clock_out_enable_n, .clock_out_pin_oe, .clock_out_pin_is_io,
  .clock_in_pin_is_io, .powerup_timer_en, .watchdog_timer_en, .periph_rc_req, .periph_rc_en,
  .lf_osc_en, .sys_src);

// File: osc_ext_src.sv
// external logic-level clock source and its config word
`timescale 1ns/1ps
module osc_ext_src (
  // mode request from the bench
  input wire logic [1:0] mode,
  // config word and clock pin
  output logic [1:0] boot_clock_select,
  output logic ext_clk
);
  // config bits mirror the mode the source is built for
  assign boot_clock_select = mode;
  initial ext_clk = 1'b0;
  // rate kept inside each power range; pin held low when not external
  always begin
    #((mode == 2'h3) ? 50 : (mode == 2'h2) ? 500 : 2000);
    ext_clk = (mode != 2'h0) ? !ext_clk : 1'b0;
  end
endmodule

// File: system_oscillator_select_bench.sv
// bench for the oscillator select block
`timescale 1ns/1ps
module system_oscillator_select_bench
  import osc_pkg::*;
;
  logic mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, co_n = 1, pt = 0, wt = 0, rc = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, e, in_io, oe, hf_en, st;
  logic [1:0] mode = 2'h0, boot;
  logic [3:0] post;
  osc_src_t sys_src;
  int n_fail = 0, tests_run = 0;
  always #25 mclk = !mclk;
  osc_ext_src osc_ext_src_inst (.mode(mode), .boot_clock_select(boot), .ext_clk());
  osc_select osc_select_inst (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .boot_clock_select(boot), .clock_out_enable_n(co_n),
    .powerup_timer_en(pt), .watchdog_timer_en(wt), .sleep_mode(rc), .periph_rc_req(rc),
    .clock_in_pin_is_io(in_io), .clock_out_pin_oe(oe), .clock_out_pin_is_io(), .hf_osc_en(hf_en),
    .lf_osc_en(), .periph_rc_en(), .startup_osc_active(st), .sys_src(sys_src),
    .hf_postscale(post), .route_sel());
  task automatic print_verdict();
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // bounded wait for the system clock source
  task automatic wsrc(input osc_src_t s);
    for (int i = 0; i < 300 && sys_src !== s; i++) @(posedge mclk);
    chk(sys_src, s);
  endtask
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
  endtask
  // reset values, then lf and hf selection
  task automatic t_internal();
    apb(0, 12'h000, 0); chk(q, 32'h38); chk(post, 4'h7);
    apb(1, 12'h000, 32'h02); wsrc(osc_src_lf);
    apb(0, 12'h004, 0); chk(q & 32'h2, 32'h2);
    apb(1, 12'h000, 32'h7A); wsrc(osc_src_hf); chk(hf_en, 1);
    repeat (100) @(posedge mclk);
    apb(0, 12'h004, 0); chk(q & 32'h11, 32'h11); chk(st, 0); chk(post, 4'hF);
  endtask
  // routing, unmapped access, pins and requests
  task automatic t_misc();
    apb(1, 12'h008, 32'h1F); apb(0, 12'h008, 0); chk(q, 32'h1F);
    apb(1, 12'h00C, 32'hFF); chk(e, 1);
    apb(0, 12'h00C, 0); chk(e, 1); chk(q, 0);
    co_n <= 1'b0; rc <= 1'b1; pt <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(oe, 1);
    co_n <= 1'b1; rc <= 1'b0; pt <= 1'b0; wt <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(oe, 0); wt <= 1'b0;
  endtask
  // external boot source, then run-time switch to internal
  task automatic t_external();
    mode <= 2'h3;
    do_reset();
    wsrc(osc_src_ext_high); chk(in_io, 0);
    apb(1, 12'h000, 32'h3A); wsrc(osc_src_hf);
    apb(1, 12'h000, 32'h38); wsrc(osc_src_ext_high);
  endtask
  initial begin
    do_reset();
    t_internal();
    t_misc();
    t_external();
    print_verdict();
  end
  // hang guard sized well above the expected run
  initial begin
    #1000000;
    n_fail++;
    print_verdict();
  end
endmodule
